/* rtl/pcs_pkg.sv */
package pcs_pkg;
   // register map, byte addresses
   localparam logic [7:0] CTRL_OFS  = 8'h00;
   localparam logic [7:0] STAT_OFS  = 8'h04;
   localparam logic [7:0] RMCNT_OFS = 8'h08;
   localparam logic [1:0] CTRL_RST  = 2'h0;
   localparam int CTRL_WIDE_BIT     = 0;
   localparam int CTRL_RMEN_BIT     = 1;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;
   // serial lane sync and rate match
   localparam logic [6:0] SYNC_COMMAS = 7'h7f;
   localparam logic [1:0] LOSS_ERRS   = 2'h3;
   localparam logic [7:0] GOOD_RUN    = 8'hff;
   localparam int RM_PPM              = 200;
   localparam logic [9:0] CTL_P = 10'h305;
   localparam logic [9:0] CTL_N = 10'h0fa;
   localparam logic [9:0] SKP_P = 10'h117;
   localparam logic [9:0] SKP_N = 10'h2e8;
   // four-lane deskew
   localparam logic [3:0] A_WINDOW = 4'ha;
   localparam logic [1:0] A_MORE   = 2'h3;
   localparam logic [2:0] A_MISS   = 3'h4;
   // special characters
   localparam logic [7:0] K28_0 = 8'h1c;
   localparam logic [7:0] K28_3 = 8'h7c;
   localparam logic [7:0] K28_4 = 8'h9c;
   localparam logic [7:0] K28_5 = 8'hbc;
   localparam logic [7:0] K27_7 = 8'hfb;
   localparam logic [7:0] K29_7 = 8'hfd;
   localparam logic [7:0] K30_7 = 8'hfe;
   localparam logic [7:0] X_IDLE  = 8'h07;
   localparam logic [7:0] X_SEQ   = 8'h9c;
   localparam logic [7:0] X_START = 8'hfb;
   localparam logic [7:0] X_TERM  = 8'hfd;
   localparam logic [7:0] X_ERR   = 8'hfe;

   typedef struct packed {
      logic       err;
      logic       k;
      logic [7:0] d;
   } sym_s;

   typedef enum logic [1:0] {SS_LOSS = 2'b01, SS_SYNC = 2'b10} ssync_e;
   typedef enum logic [2:0] {DS_IDLE = 3'b001, DS_CHECK = 3'b010, DS_ALIGN = 3'b100} dsk_e;
endpackage

/* rtl/pcs_align.sv */
// Overview of operation
// - sync after 127 valid commas
// - lose sync at three code errors
// - 255 good groups decrement error count
// - commas matched as 10-bit patterns only
// - rate matcher absorbs 200 ppm total
// - K28.5 control, K29.7 skip, matched disparity
// - rate matcher runs only when synchronized
// - control then skip: insert or delete skip
// - one skip change per cluster at most
// - data byte encodes as data group
// - idle becomes K28.0, K28.5 after terminate
// - 9C FB FD FE mapped, others K30.7
// - inverse decode, invalid group gives FE
// - deskew starts when all lanes synced
// - pointers frozen until first align group
// - after align, write runs, read frozen
// - all aligns within ten cycles: release together
// - aligned after three more aligned columns
// - lanes_aligned output shows alignment
// - four misaligned columns drop alignment
// - serial mode has no deskew
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module pcs_align #(
   parameter int RM_DEPTH  = 8,
   parameter int DSK_DEPTH = 16
) (
   // clock and reset
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   // axi4-lite slave
   input  wire logic [7:0]            awaddr,
   input  wire logic                  awvalid,
   output logic                       awready,
   input  wire logic [31:0]           wdata,
   input  wire logic [3:0]            wstrb,
   input  wire logic                  wvalid,
   output logic                       wready,
   output logic [1:0]                 bresp,
   output logic                       bvalid,
   input  wire logic                  bready,
   input  wire logic [7:0]            araddr,
   input  wire logic                  arvalid,
   output logic                       arready,
   output logic [31:0]                rdata,
   output logic [1:0]                 rresp,
   output logic                       rvalid,
   input  wire logic                  rready,
   // single-lane receive
   input  wire logic [9:0]            ser_cg,
   input  wire logic                  ser_valid,
   input  wire logic                  ser_cg_err,
   input  wire logic                  rm_rd,
   output logic [9:0]                 rm_out,
   output logic                       rm_vld,
   output logic                       rm_ins,
   output logic                       rm_del,
   output logic                       rm_full,
   output logic                       rm_empty,
   output logic                       ser_sync,
   // four-lane receive
   input  wire pcs_pkg::sym_s [3:0]   lane_sym,
   input  wire logic [3:0]            lane_sync,
   output logic [31:0]                rxd,
   output logic [3:0]                 rxc,
   output logic                       lanes_aligned,
   // four-lane transmit
   input  wire logic [31:0]           txd,
   input  wire logic [3:0]            txc,
   output pcs_pkg::sym_s [3:0]        tx_sym
);
   localparam int RAW = $clog2(RM_DEPTH);
   localparam int DAW = $clog2(DSK_DEPTH);
   // thresholds leave room either way for one skip per cluster at 200 ppm
   localparam logic [RAW:0] RM_HI = (RAW+1)'((RM_DEPTH * 3) / 4);
   localparam logic [RAW:0] RM_LO = (RAW+1)'(RM_DEPTH / 4);
   localparam logic [RAW:0] RM_FULLV = (RAW+1)'(RM_DEPTH);

   if (RM_DEPTH < 4 || (1 << RAW) != RM_DEPTH) begin : g_rm_chk
      $error("RM_DEPTH must be a power of two, at least 4");
   end
   if (DSK_DEPTH < 16 || (1 << DAW) != DSK_DEPTH) begin : g_dsk_chk
      $error("DSK_DEPTH must be a power of two, at least 16");
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [1:0]  ctrl_q;
   logic        aw_q, w_q;
   logic [7:0]  awa_q;
   logic [31:0] wd_q;
   logic [3:0]  ws_q;
   logic [7:0]  ins_cnt_q, del_cnt_q;
   logic        wide, rm_en;
   logic [1:0]  ec_q;
   logic [31:0] rd_mux;

   assign wide    = ctrl_q[pcs_pkg::CTRL_WIDE_BIT];
   assign rm_en   = ctrl_q[pcs_pkg::CTRL_RMEN_BIT];
   assign awready = !aw_q && !bvalid;
   assign wready  = !w_q && !bvalid;
   assign arready = !rvalid;

   always_comb begin
      case (araddr)
         pcs_pkg::CTRL_OFS:  rd_mux = {30'h0, ctrl_q};
         pcs_pkg::STAT_OFS:  rd_mux = {26'h0, rm_full, rm_empty, ec_q, lanes_aligned, ser_sync};
         pcs_pkg::RMCNT_OFS: rd_mux = {16'h0, del_cnt_q, ins_cnt_q};
         default:            rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_q <= pcs_pkg::CTRL_RST;
         aw_q   <= 1'b0;
         w_q    <= 1'b0;
         awa_q  <= 8'h00;
         wd_q   <= 32'h0;
         ws_q   <= 4'h0;
         bvalid <= 1'b0;
         bresp  <= pcs_pkg::RESP_OK;
      end else begin
         if (awvalid && awready) begin
            aw_q  <= 1'b1;
            awa_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_q  <= 1'b1;
            wd_q <= wdata;
            ws_q <= wstrb;
         end
         if (aw_q && w_q && !bvalid) begin
            aw_q   <= 1'b0;
            w_q    <= 1'b0;
            bvalid <= 1'b1;
            // status and counters are read-only, so a write there is an error
            bresp  <= (awa_q == pcs_pkg::CTRL_OFS) ? pcs_pkg::RESP_OK : pcs_pkg::RESP_ERR;
            if (awa_q == pcs_pkg::CTRL_OFS && ws_q[0]) begin
               ctrl_q <= wd_q[1:0];
            end
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata  <= 32'h0;
         rresp  <= pcs_pkg::RESP_OK;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rd_mux;
         rresp  <= (araddr == pcs_pkg::CTRL_OFS || araddr == pcs_pkg::STAT_OFS ||
                    araddr == pcs_pkg::RMCNT_OFS) ? pcs_pkg::RESP_OK : pcs_pkg::RESP_ERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   pcs_pkg::ssync_e ss_q;
   logic [6:0]      cc_q;
   logic [7:0]      gc_q;
   logic            is_comma;

   assign is_comma = (ser_cg == pcs_pkg::CTL_P) || (ser_cg == pcs_pkg::CTL_N);
   assign ser_sync = (ss_q == pcs_pkg::SS_SYNC);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ss_q <= pcs_pkg::SS_LOSS;
         cc_q <= 7'h00;
         ec_q <= 2'h0;
         gc_q <= 8'h00;
      end else if (ser_valid) begin
         case (ss_q)
            pcs_pkg::SS_LOSS: begin
               if (ser_cg_err) begin
                  cc_q <= 7'h00;
               end else if (is_comma) begin
                  if (cc_q == pcs_pkg::SYNC_COMMAS - 7'h01) begin
                     ss_q <= pcs_pkg::SS_SYNC;
                     cc_q <= 7'h00;
                     ec_q <= 2'h0;
                     gc_q <= 8'h00;
                  end else begin
                     cc_q <= cc_q + 7'h01;
                  end
               end
            end
            pcs_pkg::SS_SYNC: begin
               if (ser_cg_err) begin
                  gc_q <= 8'h00;
                  if (ec_q == pcs_pkg::LOSS_ERRS - 2'h1) begin
                     ss_q <= pcs_pkg::SS_LOSS;
                     ec_q <= 2'h0;
                  end else begin
                     ec_q <= ec_q + 2'h1;
                  end
               end else if (gc_q == pcs_pkg::GOOD_RUN - 8'h01) begin
                  gc_q <= 8'h00;
                  if (ec_q != 2'h0) begin
                     ec_q <= ec_q - 2'h1;
                  end
               end else begin
                  gc_q <= gc_q + 8'h01;
               end
            end
            default: ss_q <= pcs_pkg::SS_LOSS;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   logic [9:0]   rm_mem [RM_DEPTH];
   logic [RAW-1:0] rm_wp_q, rm_rp_q;
   logic [RAW:0] lvl_q;
   logic [1:0]   wl_q, rl_q;
   logic         wdone_q, rdone_q, rm_on, w_pair, r_pair, del_d, ins_d, rm_wr, rm_pop;
   logic [9:0]   head;

   assign rm_on    = rm_en && !wide && ser_sync;
   assign head     = rm_mem[rm_rp_q];
   assign rm_full  = (lvl_q == RM_FULLV);
   assign rm_empty = (lvl_q == '0);
   // a skip counts only behind the control of the same disparity
   assign w_pair = (wl_q[0] && ser_cg == pcs_pkg::SKP_P) || (wl_q[1] && ser_cg == pcs_pkg::SKP_N);
   assign r_pair = (rl_q[0] && head == pcs_pkg::SKP_P) || (rl_q[1] && head == pcs_pkg::SKP_N);
   assign del_d  = rm_on && ser_valid && w_pair && (lvl_q >= RM_HI) && !wdone_q;
   assign ins_d  = rm_on && rm_rd && !rm_empty && r_pair && (lvl_q <= RM_LO) && !rdone_q;
   assign rm_wr  = rm_on && ser_valid && !del_d && !rm_full;
   assign rm_pop = rm_on && rm_rd && !rm_empty && !ins_d;

   always_ff @(posedge aclk) begin
      if (rm_wr) begin
         rm_mem[rm_wp_q] <= ser_cg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !rm_on) begin
         rm_wp_q <= '0;
         rm_rp_q <= '0;
         lvl_q   <= '0;
         wl_q    <= 2'h0;
         rl_q    <= 2'h0;
         wdone_q <= 1'b0;
         rdone_q <= 1'b0;
      end else begin
         rm_wp_q <= rm_wp_q + RAW'(rm_wr);
         rm_rp_q <= rm_rp_q + RAW'(rm_pop);
         lvl_q   <= lvl_q + (RAW+1)'(rm_wr) - (RAW+1)'(rm_pop);
         if (ser_valid) begin
            wl_q    <= w_pair ? wl_q : {ser_cg == pcs_pkg::CTL_N, ser_cg == pcs_pkg::CTL_P};
            wdone_q <= del_d || (w_pair && wdone_q);
         end
         if (rm_rd && !rm_empty) begin
            rl_q    <= r_pair ? rl_q : {head == pcs_pkg::CTL_N, head == pcs_pkg::CTL_P};
            rdone_q <= ins_d || (r_pair && rdone_q);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rm_out    <= 10'h000;
         rm_vld    <= 1'b0;
         rm_ins    <= 1'b0;
         rm_del    <= 1'b0;
         ins_cnt_q <= 8'h00;
         del_cnt_q <= 8'h00;
      end else begin
         // with the matcher off the lane passes straight through
         rm_vld    <= rm_en ? (rm_on && rm_rd && !rm_empty) : ser_valid;
         rm_out    <= rm_en ? head : ser_cg;
         rm_ins    <= ins_d;
         rm_del    <= del_d;
         ins_cnt_q <= ins_cnt_q + 8'(ins_d);
         del_cnt_q <= del_cnt_q + 8'(del_d);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   function automatic pcs_pkg::sym_s enc(input logic c, input logic [7:0] d, input logic after_t);
      enc = '{err: 1'b0, k: c, d: d};
      if (c) begin
         case (d)
            pcs_pkg::X_IDLE:  enc.d = after_t ? pcs_pkg::K28_5 : pcs_pkg::K28_0;
            pcs_pkg::X_SEQ:   enc.d = pcs_pkg::K28_4;
            pcs_pkg::X_START: enc.d = pcs_pkg::K27_7;
            pcs_pkg::X_TERM:  enc.d = pcs_pkg::K29_7;
            default:          enc.d = pcs_pkg::K30_7;
         endcase
      end
   endfunction

   function automatic logic [8:0] dec(input pcs_pkg::sym_s s);
      dec = {1'b1, pcs_pkg::X_ERR};
      if (!s.err && !s.k) begin
         dec = {1'b0, s.d};
      end else if (!s.err) begin
         case (s.d)
            pcs_pkg::K28_0, pcs_pkg::K28_3, pcs_pkg::K28_5: dec = {1'b1, pcs_pkg::X_IDLE};
            pcs_pkg::K28_4: dec = {1'b1, pcs_pkg::X_SEQ};
            pcs_pkg::K27_7: dec = {1'b1, pcs_pkg::X_START};
            pcs_pkg::K29_7: dec = {1'b1, pcs_pkg::X_TERM};
            default:        dec = {1'b1, pcs_pkg::X_ERR};
         endcase
      end
   endfunction

   logic            tpend_q;
   logic            t_run;
   logic            t_here;
   pcs_pkg::sym_s [3:0] tx_d;

   always_comb begin
      t_run  = tpend_q;
      t_here = 1'b0;
      for (int i = 0; i < 4; i++) begin
         tx_d[i] = enc(txc[i], txd[i*8 +: 8], t_run);
         t_here  = t_here || (txc[i] && txd[i*8 +: 8] == pcs_pkg::X_TERM);
         t_run   = tpend_q || t_here;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tx_sym  <= '0;
         tpend_q <= 1'b0;
      end else begin
         tx_sym  <= tx_d;
         // idle in the column after a terminate column also uses K28.5
         // a terminate in two columns running keeps the next column on K28.5 too
         tpend_q <= t_here;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   pcs_pkg::dsk_e ds_q;
   pcs_pkg::sym_s [3:0] hd;
   logic [3:0] a_in, a_hd, wr_go_q, ovf;
   logic [3:0] win_q;
   logic [1:0] chk_q;
   logic [2:0] mis_q;
   logic       run, rd_go, rel, abort, clr, all_a, mis_col;

   assign run     = wide && (&lane_sync);
   assign rd_go   = (ds_q != pcs_pkg::DS_IDLE);
   assign rel     = (ds_q == pcs_pkg::DS_IDLE) && run && (&(wr_go_q | a_in)) &&
                    (win_q < pcs_pkg::A_WINDOW);
   assign abort   = (ds_q == pcs_pkg::DS_IDLE) && (|wr_go_q) && !rel &&
                    ((win_q >= pcs_pkg::A_WINDOW) || (|ovf));
   assign all_a   = &a_hd;
   assign mis_col = (|a_hd) && !all_a;
   assign clr     = !run || abort ||
                    (ds_q == pcs_pkg::DS_CHECK && mis_col) ||
                    (ds_q == pcs_pkg::DS_ALIGN && mis_col && mis_q == pcs_pkg::A_MISS - 3'h1);
   assign lanes_aligned = (ds_q == pcs_pkg::DS_ALIGN);

   for (genvar i = 0; i < 4; i++) begin : g_lane
      pcs_pkg::sym_s  mem [DSK_DEPTH];
      logic [DAW-1:0] wp_q, rp_q;
      logic           we;

      assign a_in[i] = !lane_sym[i].err && lane_sym[i].k && lane_sym[i].d == pcs_pkg::K28_3;
      assign a_hd[i] = rd_go && !hd[i].err && hd[i].k && hd[i].d == pcs_pkg::K28_3;
      assign we      = run && (wr_go_q[i] || a_in[i]);
      assign hd[i]   = mem[rp_q];
      assign ovf[i]  = (wp_q - rp_q) == DAW'(DSK_DEPTH - 1);

      always_ff @(posedge aclk) begin
         if (we) begin
            mem[wp_q] <= lane_sym[i];
         end
      end

      always_ff @(posedge aclk) begin
         if (!aresetn || clr) begin
            wp_q       <= '0;
            rp_q       <= '0;
            wr_go_q[i] <= 1'b0;
         end else begin
            wp_q       <= wp_q + DAW'(we);
            rp_q       <= rp_q + DAW'(rd_go);
            wr_go_q[i] <= wr_go_q[i] || (run && a_in[i]);
         end
      end

      AST_FROZEN: assert property (@(posedge aclk) disable iff (!aresetn)
         (!wr_go_q[i] && !rd_go) |=> $stable(rp_q) && (wp_q <= DAW'(1)))
         else $error("deskew pointers moved before first align");
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || clr) begin
         ds_q  <= pcs_pkg::DS_IDLE;
         win_q <= 4'h0;
         chk_q <= 2'h0;
         mis_q <= 3'h0;
      end else begin
         win_q <= (|wr_go_q && win_q != 4'hf) ? win_q + 4'h1 : win_q;
         case (ds_q)
            pcs_pkg::DS_IDLE: begin
               if (rel) begin
                  ds_q <= pcs_pkg::DS_CHECK;
               end
            end
            pcs_pkg::DS_CHECK: begin
               if (all_a) begin
                  if (chk_q == pcs_pkg::A_MORE) begin
                     ds_q <= pcs_pkg::DS_ALIGN;
                  end else begin
                     chk_q <= chk_q + 2'h1;
                  end
               end
            end
            pcs_pkg::DS_ALIGN: begin
               if (all_a) begin
                  mis_q <= 3'h0;
               end else if (mis_col) begin
                  mis_q <= mis_q + 3'h1;
               end
            end
            default: ds_q <= pcs_pkg::DS_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !rd_go) begin
         rxd <= {4{pcs_pkg::X_IDLE}};
         rxc <= 4'hf;
      end else begin
         for (int i = 0; i < 4; i++) begin
            {rxc[i], rxd[i*8 +: 8]} <= dec(hd[i]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   AST_SYNC127: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ser_sync) |-> $past(cc_q) == 7'h7e && $past(is_comma))
      else $error("sync declared without 127 commas");
   AST_ERR3: assert property (@(posedge aclk) disable iff (!aresetn)
      (ser_sync && ser_valid && ser_cg_err && ec_q == 2'h2) |=> !ser_sync)
      else $error("sync kept after third error");
   AST_GOOD255: assert property (@(posedge aclk) disable iff (!aresetn)
      (ser_sync && ser_valid && !ser_cg_err && gc_q == 8'hfe && ec_q == 2'h2) |=> ec_q == 2'h1)
      else $error("error count not reduced after good run");
   AST_RM_SYNC: assert property (@(posedge aclk) disable iff (!aresetn)
      (rm_ins || rm_del) |-> $past(ser_sync))
      else $error("rate matcher acted without sync");
   AST_RM_ONCE: assert property (@(posedge aclk) disable iff (!aresetn)
      rm_del |-> !$past(wdone_q))
      else $error("second skip deleted in one cluster");
   AST_TX_DATA: assert property (@(posedge aclk) disable iff (!aresetn)
      !txc[0] |=> !tx_sym[0].k && tx_sym[0].d == $past(txd[7:0]))
      else $error("data byte not passed as data group");
   AST_TX_BAD: assert property (@(posedge aclk) disable iff (!aresetn)
      (txc[1] && txd[15:8] == 8'h55) |=> tx_sym[1].k && tx_sym[1].d == pcs_pkg::K30_7)
      else $error("invalid control not sent as error");
   AST_RX_BAD: assert property (@(posedge aclk) disable iff (!aresetn)
      (rd_go && run && hd[2].err) |=> rxc[2] && rxd[23:16] == pcs_pkg::X_ERR)
      else $error("invalid group not decoded as error");
   AST_START: assert property (@(posedge aclk) disable iff (!aresetn)
      !run |=> !rd_go && wr_go_q == 4'h0)
      else $error("deskew active without all lanes synced");
   AST_ALIGN4: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(lanes_aligned) |-> $past(chk_q) == 2'h3 && $past(all_a))
      else $error("alignment declared too early");
   AST_DROP4: assert property (@(posedge aclk) disable iff (!aresetn)
      (lanes_aligned && mis_col && mis_q == 3'h3 && run) |=> !lanes_aligned)
      else $error("alignment kept after four misaligned columns");
   AST_RESET: assert property (@(posedge aclk)
      !aresetn |=> !ser_sync && !lanes_aligned && !rm_vld)
      else $error("state not cleared by reset");
   COV_SYNC:  cover property (@(posedge aclk) disable iff (!aresetn) $rose(ser_sync));
   COV_ALIGN: cover property (@(posedge aclk) disable iff (!aresetn) $rose(lanes_aligned));
   COV_INS:   cover property (@(posedge aclk) disable iff (!aresetn) rm_ins);
   COV_DEL:   cover property (@(posedge aclk) disable iff (!aresetn) rm_del);
endmodule
`default_nettype wire

/* verification/ser_src.sv */
`timescale 1ns/10ps
`default_nettype none
module ser_src (
   // clock
   input  wire logic       aclk,
   // command from bench
   input  wire logic       kind,
   input  wire logic       bad,
   input  wire logic       skp,
   // serial code groups
   output logic [9:0]      ser_cg,
   output logic            ser_valid,
   output logic            ser_cg_err
);
   logic pol_q = 1'b0;
   // disparity alternates for commas and data, as a real transmitter's would; skip clusters stay on CTL_P and SKP_P
   always_ff @(posedge aclk) begin
      pol_q      <= ~pol_q;
      ser_valid  <= 1'b1;
      ser_cg     <= skp  ? (pol_q ? pcs_pkg::CTL_P : pcs_pkg::SKP_P) :
                    kind ? (pol_q ? pcs_pkg::CTL_P : pcs_pkg::CTL_N) : {pol_q, 9'h0aa};
      ser_cg_err <= bad;
   end
endmodule
`default_nettype wire

/* verification/serial_pcs_sync_rate_match_deskew_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module serial_pcs_sync_rate_match_deskew_tb;
   logic aclk = 0, aresetn = 0, kind = 0, bad = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, txd = 0, rdata, rxd, nd;
   logic [3:0] lsync = 4'h7, txc = 0, rxc, nc, a;
   logic [1:0] bresp, rresp, r2;
   logic [9:0] ser_cg, rm_out;
   logic ser_valid, ser_cg_err, ser_sync, lanes_aligned, c, tp, sf, rm_vld, rm_ins, rm_del, rd = 0, skp = 0;
   logic [7:0] d;
   logic [8:0] e;
   logic [35:0] ev, q [$];
   pcs_pkg::sym_s [3:0] lane_sym = '0, tx_sym;
   int n_mismatch = 0, n_tests = 0, t = 0, seed = 32'hf045, r, m, n_ins = 0, n_del = 0;
   int skew [4] = '{0, 1, 2, 3};
   initial forever #2 aclk = ~aclk;
   ser_src ser_src_inst (.aclk(aclk), .kind(kind), .bad(bad), .skp(skp), .ser_cg(ser_cg),
      .ser_valid(ser_valid), .ser_cg_err(ser_cg_err));
   pcs_align pcs_align_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(),
      .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(), .bresp(bresp), .bvalid(), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(), .rdata(rdata), .rresp(rresp), .rvalid(), .rready(rready),
      .ser_cg(ser_cg), .ser_valid(ser_valid), .ser_cg_err(ser_cg_err), .rm_rd(rd), .rm_out(rm_out),
      .rm_vld(rm_vld), .rm_ins(rm_ins), .rm_del(rm_del), .rm_full(), .rm_empty(), .ser_sync(ser_sync),
      .lane_sym(lane_sym),
      .lane_sync(lsync), .rxd(rxd), .rxc(rxc), .lanes_aligned(lanes_aligned), .txd(txd), .txc(txc),
      .tx_sym(tx_sym));
   // skewed lanes: /A/ every 16 groups, a code error on lane 2, data elsewhere
   always @(posedge aclk) begin
      t <= t + 1;
      for (int l = 0; l < 4; l++)
         lane_sym[l] <= ((t - skew[l]) % 16 == 0) ? {2'b01, pcs_pkg::K28_3} :
                        (l == 2 && (t - skew[l]) % 16 == 8) ? 10'h200 : {2'b00, 8'(t - skew[l])};
   end
   always @(posedge aclk) begin
      n_ins <= n_ins + rm_ins;
      n_del <= n_del + rm_del;
      if (rm_vld && skp) chk(rm_out inside {pcs_pkg::CTL_P, pcs_pkg::CTL_N, pcs_pkg::SKP_P}, "rm word");
   end
   task automatic chk(input logic ok, input string m);
      n_tests++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("wrong value at %0t: %s", $time, m);
      end
   endtask
   // handshake signals are stable from the falling edge, so sample there
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rs);
      logic ah, wh, bh;
      @(posedge aclk);
      if (w) begin
         awaddr <= a; wdata <= dd; awvalid <= 1; wvalid <= 1; bready <= 1;
      end else begin
         araddr <= a; arvalid <= 1; rready <= 1;
      end
      for (int n = 0; n < 50; n++) begin
         @(negedge aclk);
         ah = pcs_align_inst.awready && awvalid || pcs_align_inst.arready && arvalid;
         wh = pcs_align_inst.wready && wvalid;
         bh = w ? pcs_align_inst.bvalid : pcs_align_inst.rvalid;
         if (bh) begin rs = w ? bresp : rresp; r = rdata; end
         @(posedge aclk);
         if (ah) begin awvalid <= 0; arvalid <= 0; end
         if (wh) wvalid <= 0;
         if (bh) begin bready <= 0; rready <= 0; break; end
      end
   endtask
   task automatic send(input logic k, input logic b, input int n);
      @(posedge aclk); kind <= k; bad <= b;
      repeat (n - 1) @(posedge aclk);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin #40000; n_mismatch++; summarize; end
   initial begin
      repeat (6) @(posedge aclk);
      @(negedge aclk); chk(!ser_sync && !lanes_aligned && rxd === 32'h07070707, "reset");
      aresetn <= 1;
      bus(1, 8'h10, 1, r2); chk(r2 === pcs_pkg::RESP_ERR, "wr unmapped");
      bus(0, 8'h0c, 0, r2); chk(r2 === pcs_pkg::RESP_ERR && r == 0, "rd unmapped");
      send(1, 0, 126); send(0, 0, 8); chk(ser_sync === 1'b0, "early sync");
      send(1, 0, 1); send(0, 0, 8); chk(ser_sync === 1'b1, "no sync");
      bus(0, pcs_pkg::STAT_OFS, 0, r2); chk(r2 === pcs_pkg::RESP_OK && r[0], "status");
      send(0, 1, 2); send(0, 0, 8); chk(ser_sync === 1'b1, "lost at 2");
      send(0, 1, 1); send(0, 0, 8); chk(ser_sync === 1'b0, "kept at 3");
      send(1, 0, 127); send(0, 1, 2); send(0, 0, 300); send(0, 1, 1); send(0, 0, 4);
      chk(ser_sync === 1'b1, "no decrement");
      send(0, 1, 1); send(0, 0, 4); chk(ser_sync === 1'b0, "kept at 3");
      $display("serial sync test done");
      // fifo starts empty with reads on, so the first clusters get inserts
      send(1, 0, 130); rd <= 1; skp <= 1;
      bus(1, pcs_pkg::CTRL_OFS, 2, r2);
      repeat (20) @(posedge aclk);
      rd <= 0;
      repeat (40) @(posedge aclk);
      skp <= 0;
      repeat (4) @(posedge aclk);
      bus(0, pcs_pkg::RMCNT_OFS, 0, r2);
      chk(r[7:0] == n_ins[7:0] && r[15:8] == n_del[7:0] && n_ins > 0 && n_del > 0, "rm counts");
      bus(0, pcs_pkg::STAT_OFS, 0, r2); chk(r[5:0] === 6'h21, "rm status");
      $display("rate match test done");
      tp = 0;
      for (int i = 0; i < 300; i++) begin
         @(posedge aclk);
         sf = 0;
         for (int l = 0; l < 4; l++) begin
            r = $random(seed);
            c = r[8];
            d = r[7:0];
            if (r[10:9] == 0) d = 8'h07;
            else if (r[10:9] == 1) d = r[13] ? 8'h9c : 8'hfb + r[12:11];
            e = !c ? {1'b0, d} : d == 8'h07 ? {1'b1, (tp || sf) ? pcs_pkg::K28_5 : pcs_pkg::K28_0}
              : (d inside {8'h9c, 8'hfb, 8'hfd, 8'hfe}) ? {1'b1, d} : {1'b1, pcs_pkg::K30_7};
            if (c && d == 8'hfd) sf = 1;
            nc[l] = c; nd[l*8+:8] = d; ev[l*9+:9] = e;
         end
         tp = sf;
         txd <= nd; txc <= nc; q.push_back(ev);
         @(negedge aclk);
         if (i > 0) begin
            ev = q.pop_front();
            for (int l = 0; l < 4; l++) chk(tx_sym[l] === {1'b0, ev[l*9+:9]}, "tx code");
         end
      end
      $display("encode test done");
      bus(1, pcs_pkg::CTRL_OFS, 1, r2);
      repeat (100) @(posedge aclk);
      @(negedge aclk); chk(!lanes_aligned && rxd === 32'h07070707, "deskew early");
      lsync <= 4'hf;
      for (int n = 0; n < 300 && !lanes_aligned; n++) @(negedge aclk);
      chk(lanes_aligned === 1'b1, "not aligned");
      chk(rxd === {4{rxd[7:0]}} && rxc === {4{rxc[0]}}, "columns");
      // a one-group slip on lane 3 splits every /A/ column into two misaligned ones
      @(posedge aclk); skew[3] <= 4; m = 0;
      for (int n = 0; n < 60 && m < 4; n++) begin
         @(negedge aclk);
         for (int l = 0; l < 4; l++) a[l] = rxc[l] && rxd[l*8+:8] == 8'h07;
         if (a == 4'hf) m = 0;
         else if (a != 4'h0) begin
            m++;
            chk(lanes_aligned === (m < 4), "misaligned column");
         end
      end
      chk(m == 4 && lanes_aligned === 1'b0, "never dropped");
      bus(1, pcs_pkg::CTRL_OFS, 0, r2);
      repeat (100) @(posedge aclk);
      @(negedge aclk); chk(lanes_aligned === 1'b0, "wide mode");
      $display("deskew test done");
      summarize;
   end
endmodule
`default_nettype wire
